//--- sd_sdi_regs.svh
// Constants for the SD-SDI oversampling receive and transmit path
`ifndef SD_SDI_REGS_SVH
`define SD_SDI_REGS_SVH

// ==========================================
// Stream geometry
`define SD_RX_WIDTH 20
`define SD_WORD_BITS 10
`define SD_OVERSAMPLE 11
`define SD_EDGE_CENTER 5
`define SD_PICK_W 4
`define SD_POS_W 5

// ==========================================
// Reset values
`define SD_PICK_RESET 4'h0
`define SD_COUNT_RESET 4'h0

`endif

//--- sd_sdi_pkg.sv
// Types shared by the SD-SDI recovery logic and its testbench
`include "sd_sdi_regs.svh"

package sd_sdi_pkg;

    // ==========================================
    // Recovered word with its one-cycle strobe
    typedef struct packed {
        logic [`SD_WORD_BITS-1:0] data;
        logic strobe;
    } sd_word_t;

endpackage

//--- sd_tx_replicator.sv
// Transmit side: repeats each SD-SDI bit eleven times on the parallel word
`timescale 1ns/1ps
`include "sd_sdi_regs.svh"

module sd_tx_replicator (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sd_mode,
    input wire logic [`SD_WORD_BITS-1:0] tx_sd_word,
    output logic tx_word_taken,
    output logic [`SD_RX_WIDTH-1:0] tx_parallel_word
);

    // ==========================================
    // State
    logic [`SD_WORD_BITS-1:0] cur, next_cur, nxt, next_nxt;
    logic [`SD_PICK_W-1:0] bit_idx, next_bit_idx, rep, next_rep, rep_q;
    logic next_taken;
    logic [`SD_RX_WIDTH-1:0] samples;
    logic [2*`SD_WORD_BITS-1:0] pair;
    logic [`SD_POS_W-1:0] total;

    assign pair = {nxt, cur};

    // One sample per lane; lane i belongs to bit (rep+i)/11 ahead of bit_idx
    genvar i;
    generate
        for (i = 0; i < `SD_RX_WIDTH; i++) begin : g_lane
            logic [`SD_POS_W-1:0] off;
            logic [`SD_POS_W-1:0] idx;
            assign off = `SD_POS_W'(rep) + `SD_POS_W'(i);
            assign idx = `SD_POS_W'(bit_idx) + ((off >= `SD_POS_W'(2*`SD_OVERSAMPLE)) ? `SD_POS_W'(2) :
                         (off >= `SD_POS_W'(`SD_OVERSAMPLE)) ? `SD_POS_W'(1) : `SD_POS_W'(0));
            assign samples[i] = pair[idx];
        end
    endgenerate

    // Advance by 20 samples; a bit wrap pulls in the next word
    always_comb begin
        total = `SD_POS_W'(rep) + `SD_POS_W'(`SD_RX_WIDTH);
        next_cur = cur;
        next_nxt = nxt;
        next_taken = 1'b0;
        if (total >= `SD_POS_W'(2*`SD_OVERSAMPLE)) begin
            next_rep = `SD_PICK_W'(total - `SD_POS_W'(2*`SD_OVERSAMPLE));
            next_bit_idx = bit_idx + `SD_PICK_W'(2);
        end else begin
            next_rep = `SD_PICK_W'(total - `SD_POS_W'(`SD_OVERSAMPLE));
            next_bit_idx = bit_idx + `SD_PICK_W'(1);
        end
        if (next_bit_idx >= `SD_PICK_W'(`SD_WORD_BITS)) begin
            next_bit_idx = next_bit_idx - `SD_PICK_W'(`SD_WORD_BITS);
            next_cur = nxt;
            next_nxt = tx_sd_word;
            next_taken = 1'b1;
        end
        if (!sd_mode) begin
            next_rep = `SD_PICK_RESET;
            next_bit_idx = `SD_PICK_RESET;
            next_taken = 1'b0;
        end
    end

    // Registers; the output word is held at zero outside SD mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur <= '0;
            nxt <= '0;
            rep <= `SD_PICK_RESET;
            rep_q <= `SD_PICK_RESET;
            bit_idx <= `SD_PICK_RESET;
            tx_word_taken <= 1'b0;
            tx_parallel_word <= '0;
        end else begin
            cur <= next_cur;
            nxt <= next_nxt;
            rep <= next_rep;
            rep_q <= rep;
            bit_idx <= next_bit_idx;
            tx_word_taken <= next_taken;
            tx_parallel_word <= sd_mode ? samples : '0;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !sd_mode);

    a_tx_copy_continues: assert property ($past(sd_mode) && rep_q != `SD_PICK_W'(0) |->
        tx_parallel_word[0] == $past(tx_parallel_word[`SD_RX_WIDTH-1])) else $error("bit run broken");
    a_tx_take_spacing: assert property (tx_word_taken |=> !tx_word_taken [*4])
        else $error("words taken too fast");
    c_tx_take: cover property (tx_word_taken ##5 tx_word_taken);

endmodule

//--- sd_sdi_oversample_recovery.sv
// SD-SDI 11x oversampling data recovery and transmit bit replication
// How it works
// - In SD mode the recovery loop hold output is driven high.
// - Receive words are free-running 11x samples, never aligned to bit edges.
// - One best sample per bit is picked, centred between detected transitions.
// - No clock is recovered; a one-cycle strobe marks each complete 10-bit word.
// - Strobe cadence averages 27 MHz, normally 5 then 6 cycles apart.
// - The SD clock enable follows the strobe with identical cadence.
// - Phase nudges let a two-pulse span shrink to 10 or stretch to 12 cycles.
// - Only the 270 Mb/s rate is handled by this recovery unit.
// - Transmit repeats each outgoing bit 11 times on the parallel word.
`timescale 1ns/1ps
`include "sd_sdi_regs.svh"

module sd_sdi_oversample_recovery (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sd_mode,
    input wire logic [`SD_RX_WIDTH-1:0] rx_parallel_word,
    input wire logic [`SD_WORD_BITS-1:0] tx_sd_word,
    output logic cdr_frequency_hold,
    output sd_sdi_pkg::sd_word_t rx_recovered,
    output logic sd_word_clock_enable,
    output logic tx_word_taken,
    output logic [`SD_RX_WIDTH-1:0] tx_parallel_word
);

    // ==========================================
    // Receive state
    logic [`SD_PICK_W-1:0] pick, next_pick;
    logic [`SD_PICK_W-1:0] count, next_count;
    logic [`SD_WORD_BITS+1:0] hist, next_hist;
    logic last_sample, next_last_sample;
    sd_sdi_pkg::sd_word_t next_recovered;
    logic next_hold;
    logic [`SD_RX_WIDTH-1:0] diff;
    logic edge_found;
    logic [`SD_POS_W-1:0] edge_pos;
    logic [`SD_POS_W:0] phase_gap;
    logic take_two;
    logic bit_a, bit_b;
    logic [`SD_PICK_W-1:0] total;
    logic [`SD_POS_W-1:0] far_pos;
    logic [`SD_RX_WIDTH:0] ext;

    // Transition map across the word, seamed to the previous word's last sample
    genvar i;
    generate
        for (i = 0; i < `SD_RX_WIDTH; i++) begin : g_diff
            if (i == 0) begin : g_first
                assign diff[i] = rx_parallel_word[i] ^ last_sample;
            end else begin : g_rest
                assign diff[i] = rx_parallel_word[i] ^ rx_parallel_word[i-1];
            end
        end
    endgenerate

    // Lane 0 is the previous word's last sample, so the pick may slide one sample before the word start
    assign ext = {rx_parallel_word, last_sample};
    assign far_pos = `SD_POS_W'(pick) + `SD_POS_W'(`SD_OVERSAMPLE);

    // Pick samples, pack bits into words and steer the sampling phase.
    // The sampler is free-running only the chosen lane moves.
    always_comb begin
        edge_found = 1'b0;
        edge_pos = '0;
        for (int k = `SD_RX_WIDTH - 1; k >= 0; k--) begin
            if (diff[k]) begin
                edge_found = 1'b1;
                edge_pos = `SD_POS_W'(k);
            end
        end
        take_two = pick < `SD_PICK_W'(`SD_RX_WIDTH - `SD_OVERSAMPLE + 1);
        bit_a = ext[pick];
        bit_b = ext[far_pos];
        next_hist = take_two ? {bit_b, bit_a, hist[`SD_WORD_BITS+1:2]} : {bit_a, hist[`SD_WORD_BITS+1:1]};
        total = count + (take_two ? `SD_PICK_W'(2) : `SD_PICK_W'(1));
        next_count = total;
        next_recovered.data = rx_recovered.data;
        next_recovered.strobe = 1'b0;
        // A full word strobes for one cycle; the eleventh bit carries over
        if (total == `SD_PICK_W'(`SD_WORD_BITS)) begin
            next_recovered.data = next_hist[`SD_WORD_BITS+1:2];
            next_recovered.strobe = 1'b1;
            next_count = `SD_COUNT_RESET;
        end else if (total == `SD_PICK_W'(`SD_WORD_BITS + 1)) begin
            next_recovered.data = next_hist[`SD_WORD_BITS:1];
            next_recovered.strobe = 1'b1;
            next_count = `SD_PICK_W'(1);
        end
        next_pick = take_two ? pick + `SD_PICK_W'(2) : pick - `SD_PICK_W'(`SD_RX_WIDTH - `SD_OVERSAMPLE);
        // Nudge toward the bit centre; sliding past a word end drops or gains a bit (span 10 or 12)
        phase_gap = ({1'b0, edge_pos} + (`SD_POS_W+1)'(`SD_EDGE_CENTER + 1 + 2*`SD_OVERSAMPLE)
                     - (`SD_POS_W+1)'(pick)) % (`SD_POS_W+1)'(`SD_OVERSAMPLE);
        if (edge_found && phase_gap != '0) begin
            if (phase_gap <= (`SD_POS_W+1)'(`SD_EDGE_CENTER)) begin
                next_pick = next_pick + `SD_PICK_W'(1);
            end else begin
                next_pick = next_pick - `SD_PICK_W'(1);
            end
        end
        next_last_sample = rx_parallel_word[`SD_RX_WIDTH-1];
        next_hold = sd_mode;
        // Fixed 270 Mb/s geometry; other SD rates need a fractional unit
        if (!sd_mode) begin
            next_pick = `SD_PICK_RESET;
            next_count = `SD_COUNT_RESET;
            next_recovered.strobe = 1'b0;
        end
    end

    // Receive registers; enable is the strobe one cycle on, same spacing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pick <= `SD_PICK_RESET;
            count <= `SD_COUNT_RESET;
            hist <= '0;
            last_sample <= 1'b0;
            rx_recovered <= '0;
            cdr_frequency_hold <= 1'b0;
            sd_word_clock_enable <= 1'b0;
        end else begin
            pick <= next_pick;
            count <= next_count;
            hist <= next_hist;
            last_sample <= next_last_sample;
            rx_recovered <= next_recovered;
            cdr_frequency_hold <= next_hold;
            sd_word_clock_enable <= rx_recovered.strobe;
        end
    end

    // ==========================================
    // Transmit replication
    sd_tx_replicator u_tx (
        .sys_clk(sys_clk),
        .rst(rst),
        .sd_mode(sd_mode),
        .tx_sd_word(tx_sd_word),
        .tx_word_taken(tx_word_taken),
        .tx_parallel_word(tx_parallel_word)
    );

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !sd_mode);

    a_hold_follows_mode: assert property (sd_mode |=> cdr_frequency_hold) else $error("hold not asserted");
    a_pick_in_range: assert property (pick < `SD_PICK_W'(`SD_OVERSAMPLE + 2)) else $error("pick lane out of range");
    a_bits_counted: assert property (count < `SD_PICK_W'(`SD_WORD_BITS)) else $error("bit count overflow");
    a_strobe_one_cycle: assert property (rx_recovered.strobe |=> !rx_recovered.strobe [*3])
        else $error("strobe too close");
    a_strobe_cadence: assert property ($past(sd_mode, 2) && rx_recovered.strobe |-> ##[4:7] rx_recovered.strobe)
        else $error("strobe cadence lost");
    a_enable_follows: assert property (rx_recovered.strobe |=> sd_word_clock_enable)
        else $error("enable missed strobe");
    a_enable_quiet: assert property (!rx_recovered.strobe |=> !sd_word_clock_enable)
        else $error("stray enable");
    a_word_held: assert property (!next_recovered.strobe |=> $stable(rx_recovered.data))
        else $error("word changed between strobes");

    c_gap_five: cover property (rx_recovered.strobe ##5 rx_recovered.strobe);
    c_gap_six: cover property (rx_recovered.strobe ##6 rx_recovered.strobe);
    c_nudge: cover property (edge_found && phase_gap != '0);

endmodule

//--- sd_far_end.sv
// Far-end model: serial source seen as free-running 11x samples
`timescale 1ns/1ps
`include "sd_sdi_regs.svh"

module sd_far_end (
    input wire logic sys_clk,
    input wire logic [1:0] drift,
    input wire logic [`SD_WORD_BITS-1:0] src_word,
    output logic src_take,
    output logic [`SD_RX_WIDTH-1:0] rx_parallel_word
);
    logic smp[$];
    int nbits = 0;
    int len;
    bit fill;

    // ==========================================
    // Sample source
    initial src_take = 1'b0;
    initial rx_parallel_word = 20'h00000;
    // Every 40th bit is stretched or shrunk to mimic a reference offset
    always @(negedge sys_clk) begin
        fill = smp.size() < 40;
        if (fill) begin
            for (int b = 0; b < `SD_WORD_BITS; b++) begin
                nbits++;
                len = (nbits % 40 != 0) ? 11 : (drift == 2'h1) ? 12 : (drift == 2'h2) ? 10 : 11;
                repeat (len) smp.push_back(src_word[b]);
            end
        end
        src_take <= fill;
        for (int k = 0; k < `SD_RX_WIDTH; k++) rx_parallel_word[k] <= smp.pop_front();
    end
endmodule

//--- tb_top.sv
// Testbench: recovery and transmit replication against a queue model
`timescale 1ns/1ps
`include "sd_sdi_regs.svh"

module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sd_mode = 1'b0;
    logic [1:0] drift = 2'h0;
    logic [`SD_WORD_BITS-1:0] src_word = 10'h2d1;
    logic [`SD_WORD_BITS-1:0] tx_sd_word = 10'h1b6;
    logic src_take, cdr_frequency_hold, sd_word_clock_enable, tx_word_taken;
    logic [`SD_RX_WIDTH-1:0] rx_parallel_word, tx_parallel_word;
    sd_sdi_pkg::sd_word_t rx_recovered;
    integer seed = 32'hbd6de037;
    int mismatches = 0;
    int compares = 0;
    int gap, last_gap, s10, s11, s12, r;
    logic rx_exp[$], rx_got[$], tx_exp[$], tx_smp[$], tx_got[$];
    logic mode_s, rst_s, stb_s, take_pend;
    logic [`SD_WORD_BITS-1:0] data_s;

    sd_far_end u_far (.sys_clk(sys_clk), .drift(drift), .src_word(src_word), .src_take(src_take),
        .rx_parallel_word(rx_parallel_word));
    sd_sdi_oversample_recovery u_dut (.sys_clk(sys_clk), .rst(rst), .sd_mode(sd_mode),
        .rx_parallel_word(rx_parallel_word), .tx_sd_word(tx_sd_word),
        .cdr_frequency_hold(cdr_frequency_hold), .rx_recovered(rx_recovered),
        .sd_word_clock_enable(sd_word_clock_enable), .tx_word_taken(tx_word_taken),
        .tx_parallel_word(tx_parallel_word));

    // ==========================================
    // Helpers
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Framing of the recovered stream is unknown, so the match may start anywhere early
    function automatic int diffs(ref logic a[$], ref logic b[$], input int o);
        int n = 0;
        if (a.size() < o + 200 || b.size() < 200) return 1;
        for (int i = 0; i < 200; i++) n += (a[o+i] !== b[i]);
        return n;
    endfunction

    function automatic bit aligned(ref logic got[$], ref logic exp[$]);
        for (int o = 0; o < 80; o++) begin
            if (diffs(got, exp, o) == 0 || diffs(exp, got, o) == 0) return 1'b1;
        end
        return 1'b0;
    endfunction

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================
    // Clock and monitor
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Inputs are read before the edge, outputs 1 ns after it
    always @(posedge sys_clk) begin
        mode_s = sd_mode;
        rst_s = rst;
        stb_s = rx_recovered.strobe;
        data_s = rx_recovered.data;
        if (src_take) begin
            for (int b = 0; b < 10; b++) rx_exp.push_back(src_word[b]);
            src_word <= 10'($random(seed));
        end
        #1;
        chk(cdr_frequency_hold === (mode_s & !rst_s), "hold level");
        if (!rst_s && !mode_s) chk(tx_parallel_word === 20'h00000 && !tx_word_taken, "parked");
        if (!rst_s && mode_s) begin
            chk(sd_word_clock_enable === stb_s, "enable cadence");
            if (!rx_recovered.strobe) chk(rx_recovered.data === data_s, "word moved");
            for (int k = 0; k < 20; k++) tx_smp.push_back(tx_parallel_word[k]);
            if (tx_word_taken) begin
                for (int b = 0; b < 10; b++) tx_exp.push_back(tx_sd_word[b]);
                take_pend = 1'b1;
            end
            if (gap >= 0) gap++;
            if (rx_recovered.strobe) begin
                chk(stb_s === 1'b0, "strobe width");
                for (int b = 0; b < 10; b++) rx_got.push_back(rx_recovered.data[b]);
                if (gap > 0 && last_gap > 0) begin
                    chk((gap + last_gap) inside {[10:12]}, "span");
                    s10 += (gap + last_gap == 10);
                    s11 += (gap + last_gap == 11);
                    s12 += (gap + last_gap == 12);
                end
                last_gap = gap;
                gap = 0;
            end
        end
    end

    // Next transmit word is offered once the last one was taken
    always @(negedge sys_clk) begin
        if (take_pend) tx_sd_word <= 10'($random(seed));
        take_pend = 1'b0;
    end

    // ==========================================
    // Main sequence: one phase per drift setting
    initial begin
        take_pend = 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        for (int d = 0; d < 3; d++) begin
            sd_mode = 1'b0;
            drift = d[1:0];
            repeat (12) @(negedge sys_clk);
            rx_exp.delete();
            rx_got.delete();
            tx_exp.delete();
            tx_smp.delete();
            tx_got.delete();
            {gap, last_gap, s10, s11, s12, r} = {-32'sd1, -32'sd1, 128'h0};
            sd_mode = 1'b1;
            repeat (900) @(negedge sys_clk);
            foreach (tx_smp[i]) begin
                r++;
                if (i + 1 < tx_smp.size() && tx_smp[i+1] !== tx_smp[i]) begin
                    if (r != i + 1) chk(r % 11 == 0, "run length");
                    repeat (r / 11) tx_got.push_back(tx_smp[i]);
                    r = 0;
                end
            end
            repeat (30) void'(rx_got.pop_front());
            chk(aligned(rx_got, rx_exp), "recovered bits");
            chk(aligned(tx_got, tx_exp), "sent bits");
            chk(s11 > s10 + s12, "cadence");
            chk(d != 1 || s12 > 0, "slow span");
            chk(d != 2 || s10 > 0, "fast span");
            $display("test drift %0d done", d);
        end
        tally_and_finish;
    end
endmodule
